// File: src/emtm_pkg.sv
package emtm_pkg;

   //------------------------------------------------------------
   // Bus timing modes
   //------------------------------------------------------------
   typedef enum logic [2:0]
   {
      EMTM_BC  = 3'b001,
      EMTM_HS  = 3'b010,
      EMTM_DDR = 3'b100
   } emtm_mode_t;

   // Mode select codes carried with an accepted switch command
   localparam logic [1:0] SEL_BC  = 2'h0;
   localparam logic [1:0] SEL_HS  = 2'h1;
   localparam logic [1:0] SEL_DDR = 2'h2;

   // Reset value of the timing mode
   localparam emtm_mode_t MODE_RST = EMTM_BC;

   //------------------------------------------------------------
   // Data path shape
   //------------------------------------------------------------
   localparam int DAT_W      = 8;
   localparam int WORD_W     = 16;
   localparam int FIFO_DEPTH = 8;
   localparam int LO_LSB     = 0;
   localparam int HI_LSB     = 8;

   //------------------------------------------------------------
   // Bus clock limits the host keeps
   //------------------------------------------------------------
   localparam int F_OD_MAX_KHZ     = 400;
   localparam int F_OD_TOL_KHZ     = 20;
   localparam int F_PP_BC_MAX_MHZ  = 26;
   localparam int F_PP_HS_MAX_MHZ  = 52;
   localparam int DDR_DUTY_MIN_PCT = 45;
   localparam int DDR_DUTY_MAX_PCT = 55;

   // Core clock and handshake bound
   localparam int REF_CLK_NS      = 25;
   localparam int HSK_MAX_CYC     = 20;

   // True where all outputs launch from the falling bus clock edge
   function automatic logic isBc(input emtm_mode_t m);
      isBc = (m == EMTM_BC);
   endfunction

endpackage

// File: src/emtm_sync.sv
`timescale 1ns/1ps
module emtm_sync
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic dIn,
   output logic      dOut
);
   logic stage1_ff;
   logic nxt_stage1;
   logic nxt_dOut;

   // Next values of the two stages
   always_comb
   begin
      nxt_stage1 = dIn;
      nxt_dOut   = stage1_ff;
   end

   // Two flip-flop level synchroniser
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         stage1_ff <= 1'b0;
         dOut      <= 1'b0;
      end
      else
      begin
         stage1_ff <= nxt_stage1;
         dOut      <= nxt_dOut;
      end
   end
endmodule

// File: src/emtm_fifo.sv
`timescale 1ns/1ps
module emtm_fifo
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
)
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wrPtr_ff;
   logic [PTR_W-1:0] rdPtr_ff;
   logic [CNT_W-1:0] count_ff;
   logic [PTR_W-1:0] nxt_wrPtr;
   logic [PTR_W-1:0] nxt_rdPtr;
   logic [CNT_W-1:0] nxt_count;
   logic             doWr;
   logic             doRd;
   logic             inReady_ff;
   logic             nxt_inReady;

   // Pointer wrap
   function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
      bump = (p == PTR_LAST) ? '0 : PTR_W'(p + 1'b1);
   endfunction

   // Flags and handshake
   assign inReady  = inReady_ff;
   assign outValid = (count_ff != '0);
   assign outData  = mem[rdPtr_ff];
   assign doWr     = inValid && inReady;
   assign doRd     = outValid && outReady;

   // Next pointers and fill level
   always_comb
   begin
      nxt_wrPtr = doWr ? bump(wrPtr_ff) : wrPtr_ff;
      nxt_rdPtr = doRd ? bump(rdPtr_ff) : rdPtr_ff;
      nxt_count = count_ff;
      if (doWr && !doRd)
      begin
         nxt_count = CNT_W'(count_ff + 1'b1);
      end
      else if (doRd && !doWr)
      begin
         nxt_count = CNT_W'(count_ff - 1'b1);
      end
      // Ready leaves a flip-flop, one look ahead of the count
      nxt_inReady = (nxt_count != CNT_FULL);
   end

   // Pointer registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
         inReady_ff <= 1'b1;
      end
      else
      begin
         wrPtr_ff <= nxt_wrPtr;
         rdPtr_ff <= nxt_rdPtr;
         count_ff <= nxt_count;
         inReady_ff <= nxt_inReady;
      end
   end

   // Storage
   always_ff @(posedge clk)
   begin
      if (doWr)
      begin
         mem[wrPtr_ff] <= inData;
      end
   end
endmodule

// File: src/emtm_core.sv
// Functional notes
// (RL1) Reset always starts in backward-compatible timing
// (RL2) Accepted switch command changes the timing mode
// (RL3) Host stays at 26 MHz before switch
// (RL4) Identification clock at most 400 kHz plus 20
// (RL5) Any clock up to mode limit accepted
// (RL6) Backward-compatible outputs launch on falling edge
// (RL7) Host stretches low phase for setup margin
// (RL8) Both DAT edges used only in DDR
// (RL9) CMD stays rising-edge in DDR operation
// (RL10) Host keeps DDR duty between 45 and 55
// (RL11) SDR receiver captures on rising edge
// (RL12) Timing mode held in state register
`timescale 1ns/1ps
module emtm_core
   import emtm_pkg::*;
(
   input  wire logic                        ref_clk,
   input  wire logic                        rst,
   input  wire logic                        switchReq,
   input  wire logic [1:0]                  switchSel,
   output emtm_pkg::emtm_mode_t             modeOut,
   output logic                             switchBusy,
   input  wire logic [emtm_pkg::WORD_W-1:0] txData,
   input  wire logic                        txValid,
   output logic                             txReady,
   input  wire logic                        cmdBit,
   input  wire logic                        cmdDrive,
   input  wire logic                        openDrainIdentPhase,
   input  wire logic                        rxEnable,
   input  wire logic                        busClk,
   input  wire logic                        cmdIn,
   output logic                             cmdOut,
   output logic                             cmdOe,
   input  wire logic [emtm_pkg::DAT_W-1:0]  datIn,
   output logic      [emtm_pkg::DAT_W-1:0]  datOut,
   output logic                             datOe,
   output logic                             cmdRxBit,
   output logic      [emtm_pkg::WORD_W-1:0] rxWord,
   output logic                             rxValid
);
   //------------------------------------------------------------
   // Core domain
   //------------------------------------------------------------
   emtm_mode_t        mode_ff, nxt_mode;
   logic              modeTgl_ff, nxt_modeTgl;
   logic              swBusy_ff, nxt_swBusy;
   logic              modeAckPrev_ff, nxt_modeAckPrev;
   logic [WORD_W-1:0] txHold_ff, nxt_txHold;
   logic              txTgl_ff, nxt_txTgl;
   logic              txBusy_ff, nxt_txBusy;
   logic              txAckPrev_ff, nxt_txAckPrev;
   logic              modeAckSync, txAckSync;
   logic [WORD_W-1:0] fifoData;
   logic              fifoValid;
   logic              modeAckEdge, txAckEdge;

   // Link-side toggles and levels
   emtm_mode_t        linkMode_ff, nxt_linkMode;
   logic              modeAckTgl_ff, nxt_modeAckTgl;
   logic              modeReqPrev_ff, nxt_modeReqPrev;
   logic              txReqPrev_ff, nxt_txReqPrev;
   logic              txAckTgl_ff, nxt_txAckTgl;
   logic              wordFull_ff, nxt_wordFull;
   logic [WORD_W-1:0] word_ff, nxt_word;
   logic [DAT_W-1:0]  curHi_ff, nxt_curHi;
   logic              phase_ff, nxt_phase;
   logic [DAT_W-1:0]  riseDat_ff, nxt_riseDat;
   logic [DAT_W-1:0]  fallSrc_ff, nxt_fallSrc;
   logic              oeRise_ff, nxt_oeRise;
   logic              cmdRise_ff, nxt_cmdRise;
   logic              cmdOeRise_ff, nxt_cmdOeRise;
   logic [DAT_W-1:0]  rxLo_ff, nxt_rxLo;
   logic              rxPhase_ff, nxt_rxPhase;
   logic [WORD_W-1:0] rxWord_ff, nxt_rxWord;
   logic              rxValid_ff, nxt_rxValid;
   logic              cmdIn_ff, nxt_cmdIn;
   logic [DAT_W-1:0]  fallDat_ff;
   logic              oeFall_ff, cmdFall_ff, cmdOeFall_ff;
   logic [DAT_W-1:0]  fallIn_ff;
   logic              modeReqSync, txReqSync, cmdSync, cmdDrvSync;
   logic              odSync, rxEnSync;
   logic              modeEdge, txEdge, linkDdr;

   // Transmit words queue ahead of the crossing
   emtm_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_txFifo
   (
      .clk      (ref_clk),
      .rst      (rst),
      .inData   (txData),
      .inValid  (txValid),
      .inReady  (txReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (!txBusy_ff)
   );

   // Acknowledge toggles back into the core clock
   emtm_sync u_modeAckSync
   (
      .clk  (ref_clk),
      .rst  (rst),
      .dIn  (modeAckTgl_ff),
      .dOut (modeAckSync)
   );
   emtm_sync u_txAckSync
   (
      .clk  (ref_clk),
      .rst  (rst),
      .dIn  (txAckTgl_ff),
      .dOut (txAckSync)
   );

   assign modeAckEdge = modeAckSync ^ modeAckPrev_ff;
   assign txAckEdge   = txAckSync ^ txAckPrev_ff;
   assign modeOut     = mode_ff;
   assign switchBusy  = swBusy_ff;

   // Mode select and word hand-off
   always_comb
   begin
      nxt_mode        = mode_ff;
      nxt_modeTgl     = modeTgl_ff;
      nxt_swBusy      = swBusy_ff;
      nxt_modeAckPrev = modeAckSync;
      nxt_txHold      = txHold_ff;
      nxt_txTgl       = txTgl_ff;
      nxt_txBusy      = txBusy_ff;
      nxt_txAckPrev   = txAckSync;
      if (swBusy_ff && modeAckEdge)
      begin
         nxt_swBusy = 1'b0;
      end
      // (RL2) switch command accepted
      if (switchReq && !swBusy_ff && switchSel != 2'h3)
      begin
         unique case (switchSel)
            SEL_BC:  nxt_mode = EMTM_BC;
            SEL_HS:  nxt_mode = EMTM_HS;
            default: nxt_mode = EMTM_DDR;
         endcase
         nxt_modeTgl = !modeTgl_ff;
         nxt_swBusy  = 1'b1;
      end
      if (txBusy_ff && txAckEdge)
      begin
         nxt_txBusy = 1'b0;
      end
      if (fifoValid && !txBusy_ff)
      begin
         nxt_txHold = fifoData;
         nxt_txTgl  = !txTgl_ff;
         nxt_txBusy = 1'b1;
      end
   end

   // (RL1) reset to backward-compatible
   // (RL12) mode state register
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         mode_ff        <= MODE_RST;
         modeTgl_ff     <= 1'b0;
         swBusy_ff      <= 1'b0;
         modeAckPrev_ff <= 1'b0;
         txHold_ff      <= '0;
         txTgl_ff       <= 1'b0;
         txBusy_ff      <= 1'b0;
         txAckPrev_ff   <= 1'b0;
      end
      else
      begin
         mode_ff        <= nxt_mode;
         modeTgl_ff     <= nxt_modeTgl;
         swBusy_ff      <= nxt_swBusy;
         modeAckPrev_ff <= nxt_modeAckPrev;
         txHold_ff      <= nxt_txHold;
         txTgl_ff       <= nxt_txTgl;
         txBusy_ff      <= nxt_txBusy;
         txAckPrev_ff   <= nxt_txAckPrev;
      end
   end

   //------------------------------------------------------------
   // Link domain
   //------------------------------------------------------------
   emtm_sync u_modeReqSync
   (
      .clk (busClk), .rst (rst), .dIn (modeTgl_ff), .dOut (modeReqSync)
   );
   emtm_sync u_txReqSync
   (
      .clk (busClk), .rst (rst), .dIn (txTgl_ff), .dOut (txReqSync)
   );
   emtm_sync u_cmdSync
   (
      .clk (busClk), .rst (rst), .dIn (cmdBit), .dOut (cmdSync)
   );
   emtm_sync u_cmdDrvSync
   (
      .clk (busClk), .rst (rst), .dIn (cmdDrive), .dOut (cmdDrvSync)
   );
   emtm_sync u_odSync
   (
      .clk  (busClk),
      .rst  (rst),
      .dIn  (openDrainIdentPhase),
      .dOut (odSync)
   );
   emtm_sync u_rxEnSync
   (
      .clk (busClk), .rst (rst), .dIn (rxEnable), .dOut (rxEnSync)
   );

   assign modeEdge = modeReqSync ^ modeReqPrev_ff;
   assign txEdge   = txReqSync ^ txReqPrev_ff;
   assign linkDdr  = (linkMode_ff == EMTM_DDR);

   // (RL5) no edge counting, any slow clock works
   always_comb
   begin
      nxt_linkMode    = linkMode_ff;
      nxt_modeAckTgl  = modeAckTgl_ff;
      nxt_modeReqPrev = modeReqSync;
      nxt_txReqPrev   = txReqSync;
      nxt_txAckTgl    = txAckTgl_ff;
      nxt_wordFull    = wordFull_ff;
      nxt_word        = word_ff;
      nxt_curHi       = curHi_ff;
      nxt_phase       = phase_ff;
      nxt_riseDat     = riseDat_ff;
      nxt_oeRise      = 1'b0;
      if (modeEdge)
      begin
         nxt_linkMode   = mode_ff;
         nxt_modeAckTgl = !modeAckTgl_ff;
      end
      if (phase_ff)
      begin
         nxt_riseDat = curHi_ff;
         nxt_oeRise  = 1'b1;
         nxt_phase   = 1'b0;
      end
      else if (wordFull_ff)
      begin
         nxt_riseDat  = word_ff[LO_LSB +: DAT_W];
         nxt_oeRise   = 1'b1;
         nxt_wordFull = 1'b0;
         nxt_txAckTgl = !txAckTgl_ff;
         nxt_curHi    = word_ff[HI_LSB +: DAT_W];
         nxt_phase    = !linkDdr;
      end
      if (txEdge)
      begin
         nxt_wordFull = 1'b1;
         nxt_word     = txHold_ff;
      end
      // (RL8) falling half carries high byte
      nxt_fallSrc = (linkDdr && !phase_ff && wordFull_ff) ?
                    word_ff[HI_LSB +: DAT_W] : nxt_riseDat;
      nxt_cmdRise = cmdSync;
      // (RL4) identification phase drives low only
      nxt_cmdOeRise = cmdDrvSync && (!odSync || !cmdSync);
   end

   // Receive capture and pairing
   always_comb
   begin
      nxt_rxLo    = rxLo_ff;
      nxt_rxPhase = rxPhase_ff;
      nxt_rxWord  = rxWord_ff;
      nxt_rxValid = 1'b0;
      // (RL11) rising-edge capture of CMD
      nxt_cmdIn   = cmdIn;
      if (!rxEnSync)
      begin
         nxt_rxPhase = 1'b0;
      end
      else if (linkDdr)
      begin
         // (RL8) pair rising and falling bytes
         nxt_rxLo    = datIn;
         nxt_rxPhase = 1'b1;
         if (rxPhase_ff)
         begin
            nxt_rxWord  = {fallIn_ff, rxLo_ff};
            nxt_rxValid = 1'b1;
         end
      end
      else if (rxPhase_ff)
      begin
         // (RL11) two rising-edge bytes per word
         nxt_rxWord  = {datIn, rxLo_ff};
         nxt_rxValid = 1'b1;
         nxt_rxPhase = 1'b0;
      end
      else
      begin
         nxt_rxLo    = datIn;
         nxt_rxPhase = 1'b1;
      end
   end

   // Rising-edge link registers
   always_ff @(posedge busClk or posedge rst)
   begin
      if (rst)
      begin
         linkMode_ff    <= MODE_RST;
         modeAckTgl_ff  <= 1'b0;
         modeReqPrev_ff <= 1'b0;
         txReqPrev_ff   <= 1'b0;
         txAckTgl_ff    <= 1'b0;
         wordFull_ff    <= 1'b0;
         word_ff        <= '0;
         curHi_ff       <= '0;
         phase_ff       <= 1'b0;
         riseDat_ff     <= '0;
         fallSrc_ff     <= '0;
         oeRise_ff      <= 1'b0;
         cmdRise_ff     <= 1'b1;
         cmdOeRise_ff   <= 1'b0;
         rxLo_ff        <= '0;
         rxPhase_ff     <= 1'b0;
         rxWord_ff      <= '0;
         rxValid_ff     <= 1'b0;
         cmdIn_ff       <= 1'b1;
      end
      else
      begin
         linkMode_ff    <= nxt_linkMode;
         modeAckTgl_ff  <= nxt_modeAckTgl;
         modeReqPrev_ff <= nxt_modeReqPrev;
         txReqPrev_ff   <= nxt_txReqPrev;
         txAckTgl_ff    <= nxt_txAckTgl;
         wordFull_ff    <= nxt_wordFull;
         word_ff        <= nxt_word;
         curHi_ff       <= nxt_curHi;
         phase_ff       <= nxt_phase;
         riseDat_ff     <= nxt_riseDat;
         fallSrc_ff     <= nxt_fallSrc;
         oeRise_ff      <= nxt_oeRise;
         cmdRise_ff     <= nxt_cmdRise;
         cmdOeRise_ff   <= nxt_cmdOeRise;
         rxLo_ff        <= nxt_rxLo;
         rxPhase_ff     <= nxt_rxPhase;
         rxWord_ff      <= nxt_rxWord;
         rxValid_ff     <= nxt_rxValid;
         cmdIn_ff       <= nxt_cmdIn;
      end
   end

   // (RL6) falling-edge launch copies
   always_ff @(negedge busClk or posedge rst)
   begin
      if (rst)
      begin
         fallDat_ff   <= '0;
         oeFall_ff    <= 1'b0;
         cmdFall_ff   <= 1'b1;
         cmdOeFall_ff <= 1'b0;
         fallIn_ff    <= '0;
      end
      else
      begin
         fallDat_ff   <= fallSrc_ff;
         oeFall_ff    <= oeRise_ff;
         cmdFall_ff   <= cmdRise_ff;
         cmdOeFall_ff <= cmdOeRise_ff;
         fallIn_ff    <= datIn;
      end
   end

   // (RL6) launch edge chosen by mode
   // (RL9) CMD rising-edge outside backward mode
   assign cmdOut   = isBc(linkMode_ff) ? cmdFall_ff : cmdRise_ff;
   assign cmdOe    = isBc(linkMode_ff) ? cmdOeFall_ff : cmdOeRise_ff;
   assign datOut   = (isBc(linkMode_ff) || (linkDdr && !busClk)) ?
                     fallDat_ff : riseDat_ff;
   assign datOe    = isBc(linkMode_ff) ? oeFall_ff : oeRise_ff;
   assign cmdRxBit = cmdIn_ff;
   assign rxWord   = rxWord_ff;
   assign rxValid  = rxValid_ff;

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   // Hand-off bound as a local constant
   localparam int HSK_BOUND = HSK_MAX_CYC;
   sequence sdrLoad;
      wordFull_ff && !phase_ff && !linkDdr && !modeEdge;
   endsequence
   sequence sdrSecond;
      phase_ff ##1 (oeRise_ff && riseDat_ff == $past(curHi_ff));
   endsequence

   reset_mode_bc_a: assert property ( // RL1
      @(posedge ref_clk) disable iff (rst)
      $past(rst) |-> mode_ff == EMTM_BC) else $error("mode not reset");
   switch_hs_a: assert property ( // RL2
      @(posedge ref_clk) disable iff (rst)
      switchReq && !swBusy_ff && switchSel == SEL_HS |=>
      mode_ff == EMTM_HS && swBusy_ff) else $error("no switch to HS");
   mode_hold_a: assert property ( // RL12
      @(posedge ref_clk) disable iff (rst)
      !(switchReq && !swBusy_ff) |=> $stable(mode_ff))
      else $error("mode changed unasked");
   switch_done_a: assert property ( // RL2
      @(posedge ref_clk) disable iff (rst)
      $rose(swBusy_ff) |-> ##[1:HSK_BOUND] !swBusy_ff)
      else $error("mode hand-off stuck");
   bc_fall_out_a: assert property ( // RL6
      @(posedge busClk) disable iff (rst)
      linkMode_ff == EMTM_BC |-> cmdOut == cmdFall_ff &&
      datOut == fallDat_ff) else $error("BC not falling launch");
   ddr_cmd_rise_a: assert property ( // RL9
      @(posedge busClk) disable iff (rst)
      linkDdr |-> cmdOut == cmdRise_ff && cmdOe == cmdOeRise_ff)
      else $error("DDR CMD not rising");
   ddr_pair_a: assert property ( // RL8
      @(posedge busClk) disable iff (rst)
      wordFull_ff && !phase_ff && linkDdr && !modeEdge |=>
      riseDat_ff == $past(word_ff[LO_LSB +: DAT_W]) &&
      fallSrc_ff == $past(word_ff[HI_LSB +: DAT_W]) && !phase_ff)
      else $error("DDR byte pair wrong");
   sdr_two_beats_a: assert property ( // RL8
      @(posedge busClk) disable iff (rst)
      sdrLoad |=> sdrSecond) else $error("SDR second byte lost");
   od_no_high_a: assert property ( // RL4
      @(posedge busClk) disable iff (rst)
      odSync && cmdSync |=> !cmdOeRise_ff)
      else $error("CMD driven high in ident");
   sdr_rx_pair_a: assert property ( // RL11
      @(posedge busClk) disable iff (rst)
      rxEnSync && !linkDdr && rxPhase_ff |=> rxValid_ff &&
      rxWord_ff[HI_LSB +: DAT_W] == $past(datIn))
      else $error("SDR receive pairing wrong");
endmodule

// File: tb/emtm_host_model.sv
`timescale 1ns/1ps
module emtm_host_model
   import emtm_pkg::*;
(
   input  wire logic                       clkRun,
   input  wire logic                       bcMode,
   input  wire logic                       ddr,
   input  wire logic                       streamOn,
   input  wire logic                       cmdOut,
   input  wire logic [emtm_pkg::DAT_W-1:0] datOut,
   input  wire logic                       datOe,
   output logic                            busClk,
   output logic      [emtm_pkg::DAT_W-1:0] datIn
);
   //---------------------------------------------------------
   // Host clock, capture and edge watch
   //---------------------------------------------------------
   logic [DAT_W-1:0] got[$];
   logic [DAT_W:0]   snap;
   logic [DAT_W-1:0] seq;
   int               edgeBad;

   initial
   begin
      busClk = 1'b0;
      datIn = 8'h00;
      seq = 8'h00;
      edgeBad = 0;
      #7;
      forever
      begin
         #23;
         if (clkRun || busClk)
         begin
            if (datOe === 1'b1 && (ddr || !busClk))
               got.push_back(datOut);
            snap = {cmdOut, datOut};
            busClk = ~busClk;
            #1;
            if (bcMode && busClk && snap !== {cmdOut, datOut})
               edgeBad++;
            if (ddr && !busClk && snap[DAT_W] !== cmdOut)
               edgeBad++;
         end
         else
            #1;
      end
   end

   always @(busClk)
   begin
      #2;
      if (!streamOn)
         datIn = ~datIn;
      else if (ddr || !busClk)
      begin
         datIn = seq;
         seq = seq + 8'h01;
      end
   end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import emtm_pkg::*;
   logic              ref_clk, rst, switchReq, switchBusy, txValid, txReady;
   logic              cmdBit, cmdDrive, odPh, rxEnable, busClk, cmdIn;
   logic              cmdOut, cmdOe, datOe, cmdRxBit, rxValid, clkRun;
   logic              bcMode, ddr, streamOn, cmdHost;
   logic [1:0]        switchSel;
   logic [DAT_W-1:0]  datIn, datOut;
   logic [WORD_W-1:0] txData, rxWord;
   emtm_mode_t        modeOut;
   logic [DAT_W-1:0]  expQ[$];
   int                fail_count, total_checks, rxCnt, acc, k, n;
   integer            seed;
   logic [1:0]        sels[4] = '{SEL_BC, SEL_HS, SEL_DDR, SEL_BC};

   //---------------------------------------------------------
   // Clock, wiring and instances
   //---------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // CMD wire: carries the host level cmdHost when the core does not drive
   assign cmdIn = cmdOe ? cmdOut : cmdHost;

   emtm_core emtm_core_inst (.ref_clk(ref_clk), .rst(rst),
      .switchReq(switchReq), .switchSel(switchSel), .modeOut(modeOut),
      .switchBusy(switchBusy), .txData(txData), .txValid(txValid),
      .txReady(txReady), .cmdBit(cmdBit), .cmdDrive(cmdDrive),
      .openDrainIdentPhase(odPh), .rxEnable(rxEnable), .busClk(busClk),
      .cmdIn(cmdIn), .cmdOut(cmdOut), .cmdOe(cmdOe), .datIn(datIn),
      .datOut(datOut), .datOe(datOe), .cmdRxBit(cmdRxBit),
      .rxWord(rxWord), .rxValid(rxValid));

   emtm_host_model emtm_host_model_inst (.clkRun(clkRun),
      .bcMode(bcMode), .ddr(ddr), .streamOn(streamOn), .cmdOut(cmdOut),
      .datOut(datOut), .datOe(datOe), .busClk(busClk), .datIn(datIn));

   //---------------------------------------------------------
   // Helpers
   //---------------------------------------------------------
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic hang(input string m);
      chk(1'b0, m);
      print_verdict();
   endtask

   task automatic cyc(input int c);
      repeat (c) @(negedge ref_clk);
   endtask

   function automatic emtm_mode_t expMode(input logic [1:0] s);
      expMode = (s == SEL_HS) ? EMTM_HS : (s == SEL_DDR) ? EMTM_DDR : EMTM_BC;
   endfunction

   task automatic setMode(input logic [1:0] s);
      switchSel = s;
      switchReq = 1'b1;
      cyc(1);
      switchReq = 1'b0;
      cyc(1);
   endtask

   task automatic waitIdle(input emtm_mode_t m);
      n = 0;
      while (switchBusy !== 1'b0 && n < 60)
      begin
         cyc(1);
         n++;
      end
      if (switchBusy !== 1'b0)
         hang("switch stuck");
      bcMode = (m == EMTM_BC);
      ddr = (m == EMTM_DDR);
   endtask

   task automatic push(input logic [WORD_W-1:0] w);
      txData = w;
      txValid = 1'b1;
      n = 0;
      while (txReady !== 1'b1 && n < 400)
      begin
         cyc(1);
         n++;
      end
      if (txReady !== 1'b1)
         hang("tx stall");
      expQ.push_back(w[7:0]);
      expQ.push_back(w[15:8]);
      cyc(1);
   endtask

   task automatic drain();
      n = 0;
      while (emtm_host_model_inst.got.size() < expQ.size() && n < 4000)
      begin
         cyc(1);
         n++;
      end
      if (n == 4000)
         hang("tx drain");
      cyc(40);
      chk(emtm_host_model_inst.got.size() == expQ.size(), "tx count");
      while (expQ.size() > 0 && emtm_host_model_inst.got.size() > 0)
         chk(emtm_host_model_inst.got.pop_front() === expQ.pop_front(),
             "tx byte");
      emtm_host_model_inst.got.delete();
      expQ.delete();
   endtask

   task automatic rxCheck();
      streamOn = 1'b1;
      cyc(4);
      rxCnt = 0;
      rxEnable = 1'b1;
      cyc(80);
      rxEnable = 1'b0;
      chk(ddr ? rxCnt > 25 : (rxCnt > 10 && rxCnt < 22), "rx rate");
      cyc(12);
      streamOn = 1'b0;
   endtask

   task automatic fifoFill();
      clkRun = 1'b0;
      cyc(8);
      acc = 0;
      txValid = 1'b1;
      while (acc < 12)
      begin
         txData = 16'($random(seed));
         if (txReady !== 1'b1)
            break;
         expQ.push_back(txData[7:0]);
         expQ.push_back(txData[15:8]);
         acc++;
         cyc(1);
      end
      txValid = 1'b0;
      chk(acc >= FIFO_DEPTH && acc <= FIFO_DEPTH + 1, "fifo depth");
      cyc(4);
      chk(txReady === 1'b0, "full held");
      clkRun = 1'b1;
      drain();
   endtask

   // Received words pair low byte then high byte
   always @(posedge busClk)
      if (rxValid === 1'b1)
      begin
         rxCnt++;
         chk(rxWord[15:8] === rxWord[7:0] + 8'h01, "rx pair");
      end

   //---------------------------------------------------------
   // Main sequence
   //---------------------------------------------------------
   initial
   begin
      seed = 32'h699B;
      {fail_count, total_checks, rxCnt} = '0;
      {switchReq, txValid, cmdDrive, odPh, rxEnable, ddr, streamOn} = '0;
      {rst, cmdBit, cmdHost, clkRun, bcMode} = '1;
      switchSel = 2'h0;
      txData = 16'h0000;
      cyc(10);
      chk(modeOut === EMTM_BC && cmdOe === 1'b0 && datOe === 1'b0, "rst");
      rst = 1'b0;
      cyc(1);
      chk(modeOut === MODE_RST && switchBusy === 1'b0, "release");
      $display("test reset done");
      foreach (sels[i])
      begin
         setMode(sels[i]);
         chk(modeOut === expMode(sels[i]) && switchBusy === 1'b1, "sw");
         waitIdle(expMode(sels[i]));
         cmdDrive = 1'b1;
         for (k = 0; k < 4; k++)
            push(16'($random(seed)));
         txValid = 1'b0;
         for (k = 0; k < 3; k++)
         begin
            cmdBit = 1'($random(seed));
            cyc(16);
            chk(cmdOut === cmdBit && cmdOe === 1'b1, "cmd");
         end
         drain();
         rxCheck();
         $display("test mode %0d done", i);
      end
      setMode(2'h3);
      chk(modeOut === EMTM_BC && switchBusy === 1'b0, "sel 3");
      setMode(SEL_HS);
      cyc(1);
      chk(switchBusy === 1'b1, "busy");
      setMode(SEL_DDR);
      waitIdle(EMTM_HS);
      chk(modeOut === EMTM_HS, "busy refused");
      fifoFill();
      $display("test refusals and fifo done");
      odPh = 1'b1;
      cmdBit = 1'b1;
      cyc(16);
      chk(cmdOe === 1'b0, "od high");
      cmdBit = 1'b0;
      cyc(16);
      chk(cmdOe === 1'b1 && cmdOut === 1'b0, "od low");
      {odPh, cmdDrive} = '0;
      for (k = 0; k < 4; k++)
      begin
         cmdHost = 1'($random(seed));
         cyc(16);
         chk(cmdRxBit === cmdHost, "cmd rx");
      end
      chk(emtm_host_model_inst.edgeBad == 0, "launch edge");
      rst = 1'b1;
      cyc(10);
      rst = 1'b0;
      cyc(1);
      chk(modeOut === EMTM_BC, "reset again");
      $display("test cmd and reset done");
      print_verdict();
   end
endmodule
